// ==== rtpsr_regs.sv ====
// Pointer configuration, operational status, last command and self-test halt registers.
// Assumes the message engine on clk_sys supplies event pulses and the host uses the strobed port.
`timescale 1ns/1ps

module rtpsr_regs (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input rtpsr_pkg::rtpsr_bus_req_t bus_req,
	output logic [rtpsr_pkg::DATA_W-1:0] rdata,
	input rtpsr_pkg::rtpsr_engine_t eng,
	input wire logic illegal_cmd_pin,
	input wire logic std_variant_pin,
	input wire logic broadcast_pin,
	input wire logic ta_parity_check_on,
	input wire logic bus_a_on,
	input wire logic bus_b_on,
	output rtpsr_pkg::rtpsr_cfg_t cfg,
	output logic mem_halt,
	output logic selftest_on_clr
);
	import rtpsr_pkg::*;

	// Pin-sourced levels pass through the three-stage synchroniser.
	logic ill_pin_s;
	logic std_a_s;
	logic bdc_s;

	rtpsr_sync u_sync_ill (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.pin_in(illegal_cmd_pin),
		.pin_out(ill_pin_s)
	);

	rtpsr_sync u_sync_std (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.pin_in(std_variant_pin),
		.pin_out(std_a_s)
	);

	rtpsr_sync u_sync_bdc (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.pin_in(broadcast_pin),
		.pin_out(bdc_s)
	);

	// Decode.
	wire wr_base = bus_req.wr & (bus_req.addr == OFF_BASE_CFG);
	wire wr_halt = bus_req.wr & (bus_req.addr == OFF_ST_HALT);
	wire rd_ops = bus_req.rd & (bus_req.addr == OFF_OP_STATE);

	logic [15:0] base_cfg_q;
	logic [15:0] last_cmd_q;
	logic [15:0] rdata_q;
	logic rd_ops_q;
	logic msg_in_progress_q;
	logic selftest_running_q;
	logic term_flag_allowed_q;
	logic mode_cmd_seen_n_q;
	logic last_cmd_channel_q;
	logic halt_q;

	// Command word decode.
	wire [4:0] cw_sa = eng.cmd_word[CW_SA_LSB +: CW_SA_W];
	wire [4:0] cw_mc = eng.cmd_word[CW_MC_LSB +: CW_SA_W];
	wire cw_is_mode = (cw_sa == SA_MODE_0) | (cw_sa == SA_MODE_1);
	wire cw_tx_last = cw_is_mode & (cw_mc == MC_TX_LAST_CMD);
	wire std_b = ~std_a_s;
	wire cmd_take = eng.cmd_valid & ~(std_b & cw_tx_last);
	wire inhibit_tf = eng.cmd_valid & cw_is_mode & (cw_mc == MC_INHIBIT_TFLAG);

	// Illegal command source depends on the standard variant.
	wire illegal_evt = eng.cmd_valid & (ill_pin_s | (std_b & eng.illegal_int));

	// Read-clear flags, cleared the cycle after the read returned data.
	logic valid_msg_done;
	logic msg_fault_flag;
	logic illegal_cmd_flag;
	logic cmd_valid_flag;
	logic overrun_flag;

	rtpsr_rdclr_flag u_vmd (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.set_evt(eng.valid_msg),
		.hold_cause(1'b0),
		.rd_done(rd_ops_q),
		.flag(valid_msg_done)
	);

	rtpsr_rdclr_flag u_mf (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.set_evt(eng.msg_fault_cause),
		.hold_cause(eng.msg_fault_cause),
		.rd_done(rd_ops_q),
		.flag(msg_fault_flag)
	);

	rtpsr_rdclr_flag u_ill (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.set_evt(illegal_evt),
		.hold_cause(1'b0),
		.rd_done(rd_ops_q),
		.flag(illegal_cmd_flag)
	);

	rtpsr_rdclr_flag u_vc (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.set_evt(eng.cmd_valid),
		.hold_cause(1'b0),
		.rd_done(rd_ops_q),
		.flag(cmd_valid_flag)
	);

	rtpsr_rdclr_flag u_ov (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.set_evt(eng.overrun_cause),
		.hold_cause(eng.overrun_cause),
		.rd_done(rd_ops_q),
		.flag(overrun_flag)
	);

	// Parity error is only reported while checking is on.
	wire ta_parity_bad_n = ~(ta_parity_check_on & eng.ta_parity_err);

	wire [15:0] op_state = {
		msg_in_progress_q,
		valid_msg_done,
		msg_fault_flag,
		ta_parity_bad_n,
		selftest_running_q,
		bdc_s,
		term_flag_allowed_q,
		bus_a_on,
		bus_b_on,
		std_a_s,
		mode_cmd_seen_n_q,
		eng.tx_running,
		illegal_cmd_flag,
		last_cmd_channel_q,
		cmd_valid_flag,
		overrun_flag
	};

	wire [15:0] rd_mux = (bus_req.addr == OFF_BASE_CFG) ? base_cfg_q :
		(bus_req.addr == OFF_OP_STATE) ? op_state :
		(bus_req.addr == OFF_LAST_CMD) ? last_cmd_q : DATA_ZERO;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			base_cfg_q <= BASE_CFG_RST;
			rdata_q <= DATA_ZERO;
			rd_ops_q <= 1'b0;
		end else begin
			if (wr_base)
				base_cfg_q <= bus_req.wdata;
			rdata_q <= bus_req.rd ? rd_mux : DATA_ZERO;
			rd_ops_q <= rd_ops;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			last_cmd_q <= LAST_CMD_RST;
			last_cmd_channel_q <= 1'b0;
			mode_cmd_seen_n_q <= 1'b1;
		end else if (cmd_take) begin
			last_cmd_q <= eng.cmd_word;
			last_cmd_channel_q <= eng.cmd_on_a;
			mode_cmd_seen_n_q <= ~cw_is_mode;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			msg_in_progress_q <= 1'b0;
			selftest_running_q <= 1'b0;
			term_flag_allowed_q <= 1'b1;
			halt_q <= 1'b0;
		end else begin
			if (eng.msg_start)
				msg_in_progress_q <= 1'b1;
			else if (eng.msg_end)
				msg_in_progress_q <= 1'b0;
			if (wr_halt)
				selftest_running_q <= 1'b0;
			else if (eng.selftest_start)
				selftest_running_q <= 1'b1;
			if (inhibit_tf)
				term_flag_allowed_q <= 1'b0;
			halt_q <= wr_halt;
		end
	end

	// Pointer block word index: T/R then subaddress of the last captured command.
	wire [5:0] ptr_low = {last_cmd_q[CW_TR_BIT], last_cmd_q[CW_SA_LSB +: CW_SA_W]};

	// Bit 5 of the base config is kept for readback only.
	assign cfg.ptr_block_base_hi = base_cfg_q[15:BPC_HI_LSB];
	assign cfg.single_buf_sel = base_cfg_q[BPC_SINGLE_BIT];
	assign cfg.rx_buf_log2_size = base_cfg_q[BPC_SIZE_LSB +: BPC_SIZE_W];
	assign cfg.ptr_block_low = ptr_low;
	assign rdata = rdata_q;
	assign mem_halt = halt_q;
	assign selftest_on_clr = halt_q;

	AST_RD_LATENCY: assert property (@(posedge clk_sys) disable iff (sys_rst)
		bus_req.rd && bus_req.addr == OFF_LAST_CMD |=> rdata == $past(last_cmd_q))
		else $error("Last command read data wrong");
	AST_VMD_CLR: assert property (@(posedge clk_sys) disable iff (sys_rst)
		rd_ops ##1 !eng.valid_msg |=> !valid_msg_done)
		else $error("Valid message flag not cleared by read");
	AST_VMD_SET_WINS: assert property (@(posedge clk_sys) disable iff (sys_rst)
		eng.valid_msg |=> valid_msg_done)
		else $error("Valid message event lost");
	AST_MF_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
		msg_fault_flag && eng.msg_fault_cause |=> msg_fault_flag)
		else $error("Message fault cleared while cause persists");
	AST_OV_CLR: assert property (@(posedge clk_sys) disable iff (sys_rst)
		rd_ops ##1 (!eng.overrun_cause) |=> !overrun_flag)
		else $error("Overrun flag not cleared");
	AST_PARITY: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!ta_parity_check_on |-> op_state[12])
		else $error("Parity error shown with checking off");
	AST_HALT: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wr_halt |=> !selftest_running_q && mem_halt && selftest_on_clr)
		else $error("Halt write did not stop self-test");
	AST_CMD_KEEP: assert property (@(posedge clk_sys) disable iff (sys_rst)
		eng.cmd_valid && std_b && cw_tx_last |=> $stable(last_cmd_q))
		else $error("Transmit last command overwrote capture");
	AST_MSG_IN_PROGRESS: assert property (@(posedge clk_sys) disable iff (sys_rst)
		eng.msg_end && !eng.msg_start |=> !op_state[15])
		else $error("Message active not cleared");
	AST_TF: assert property (@(posedge clk_sys) disable iff (sys_rst)
		inhibit_tf |=> !term_flag_allowed_q ##1 !term_flag_allowed_q)
		else $error("Terminal flag enable not cleared");

	COV_OPS_READ: cover property (@(posedge clk_sys) disable iff (sys_rst) rd_ops && valid_msg_done);
	COV_SET_AND_READ: cover property (@(posedge clk_sys) disable iff (sys_rst) rd_ops_q && eng.valid_msg);
	COV_HALT: cover property (@(posedge clk_sys) disable iff (sys_rst) wr_halt && selftest_running_q);
	COV_BASE_WR: cover property (@(posedge clk_sys) disable iff (sys_rst) wr_base ##1 bus_req.rd);

endmodule

// ==== rtpsr_pkg.sv ====
// Constants, field layouts and carrier types for the remote terminal pointer and status register bank.
// Assumes a single 25 MHz system clock and a host that reaches the bank over a plain strobed port.
//
// Overview of operation
// - Base config bits 15..6 give the ten upper pointer block address lines.
// - Base config bit 5 is stored but steers nothing.
// - Base config bit 4 high means one shared receive buffer, low separate buffers.
// - Buffer size field X gives 2^X words; software keeps X within 3 to 15.
// - Status bit 15 is high while a message is in progress.
// - Status bit 14 sets on a valid message and clears on status read.
// - Status bit 13 sets on message fault; read clears unless cause persists.
// - Status bit 12 low flags address parity error, only with checking enabled.
// - Status bit 11 is high while self-test runs.
// - Status bit 10 is high when broadcast commands are accepted.
// - Status bit 9 resets high; inhibit terminal flag mode code clears it.
// - Status bits 8 and 7 show channel A and channel B enabled.
// - Status bit 6 is high in A-standard, low in B-standard.
// - Status bit 5 reads low when last captured command was a mode command.
// - Status bit 4 is high while the transmitter sends.
// - Status bit 3 sets on illegal command and clears on status read.
// - A-standard uses only the illegal pin; B-standard also internal detection.
// - Status bit 2 shows channel of last captured command, high for A.
// - Status bit 1 sets on valid command and clears on status read.
// - Status bit 0 sets on overrun; read clears unless the error persists.
// - Last command register captures valid commands except B-standard transmit last command.
// - Any write to the halt register stops memory activity and ends self-test.
// - Base config register resets to zero.
// - Low six pointer address bits come from T/R and subaddress bits.

package rtpsr_pkg;

	localparam int unsigned ADDR_W = 2;
	localparam int unsigned DATA_W = 16;

	localparam logic [1:0] OFF_BASE_CFG = 2'h0;
	localparam logic [1:0] OFF_OP_STATE = 2'h1;
	localparam logic [1:0] OFF_LAST_CMD = 2'h2;
	localparam logic [1:0] OFF_ST_HALT = 2'h3;

	localparam logic [15:0] BASE_CFG_RST = 16'h0000;
	localparam logic [15:0] LAST_CMD_RST = 16'h0410;
	localparam logic [15:0] DATA_ZERO = 16'h0000;

	localparam int unsigned BPC_HI_LSB = 6;
	localparam int unsigned BPC_SINGLE_BIT = 4;
	localparam int unsigned BPC_SIZE_LSB = 0;
	localparam int unsigned BPC_SIZE_W = 4;

	// Command word field positions (bit times 4..19 held in 15..0).
	localparam int unsigned CW_TR_BIT = 10;
	localparam int unsigned CW_SA_LSB = 5;
	localparam int unsigned CW_SA_W = 5;
	localparam int unsigned CW_MC_LSB = 0;
	localparam logic [4:0] SA_MODE_0 = 5'h00;
	localparam logic [4:0] SA_MODE_1 = 5'h1F;
	localparam logic [4:0] MC_INHIBIT_TFLAG = 5'h06;
	localparam logic [4:0] MC_TX_LAST_CMD = 5'h12;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} rtpsr_bus_req_t;

	// One-cycle pulses and levels from the message engine.
	typedef struct packed {
		logic msg_start;
		logic msg_end;
		logic valid_msg;
		logic cmd_valid;
		logic [15:0] cmd_word;
		logic cmd_on_a;
		logic illegal_int;
		logic msg_fault_cause;
		logic overrun_cause;
		logic tx_running;
		logic ta_parity_err;
		logic selftest_start;
	} rtpsr_engine_t;

	typedef struct packed {
		logic [9:0] ptr_block_base_hi;
		logic single_buf_sel;
		logic [3:0] rx_buf_log2_size;
		logic [5:0] ptr_block_low;
	} rtpsr_cfg_t;

endpackage

// ==== rtpsr_sync.sv ====
// Three-stage synchroniser for a level arriving from a pin.
// Assumes the pin is asynchronous to clk_sys; output changes once stages two and three agree.
`timescale 1ns/1ps

module rtpsr_sync (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic pin_in,
	output logic pin_out
);

	logic [2:0] stage_q;
	logic out_q;
	wire agree = stage_q[1] == stage_q[2];

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			stage_q <= 3'h0;
			out_q <= 1'b0;
		end else begin
			stage_q <= {stage_q[1:0], pin_in};
			if (agree)
				out_q <= stage_q[2];
		end
	end

	assign pin_out = out_q;

endmodule

// ==== rtpsr_rdclr_flag.sv ====
// Sticky flag that hardware sets and a status read clears.
// Assumes rd_done pulses in the same cycle as the read data is presented.
`timescale 1ns/1ps

module rtpsr_rdclr_flag (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic set_evt,
	input wire logic hold_cause,
	input wire logic rd_done,
	output logic flag
);

	logic flag_q;
	logic flag_d;

	// Setting wins over clearing, and a cause still present keeps the flag.
	assign flag_d = set_evt | (flag_q & ~rd_done) | (hold_cause & flag_q);

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			flag_q <= 1'b0;
		else
			flag_q <= flag_d;
	end

	assign flag = flag_q;

endmodule

// ==== rtpsr_eng_model.sv ====
// Behavioural message engine feeding event pulses and status levels to the register bank.
// Assumes the bench raises go for one cycle per command and leaves DWELL cycles between commands.
`timescale 1ns/1ps

module rtpsr_eng_model #(
	parameter int DWELL = 6
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic go,
	input wire logic [15:0] word,
	input wire logic on_a,
	input wire logic ill,
	input wire logic [3:0] lvl,
	input wire logic st_go,
	output rtpsr_pkg::rtpsr_engine_t eng
);
	import rtpsr_pkg::*;
	logic [7:0] cnt_q;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= 8'h00;
		end else if (go) begin
			cnt_q <= 8'(DWELL);
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end
	// Command fields mean something only beside the pulse; otherwise they show the inverse so stale data is caught.
	assign eng.cmd_word = go ? word : ~word;
	assign eng.cmd_on_a = go ? on_a : ~on_a;
	assign eng.illegal_int = go ? ill : ~ill;
	assign eng.msg_start = go;
	assign eng.cmd_valid = go;
	assign eng.msg_end = (cnt_q == 8'h01);
	assign eng.valid_msg = (cnt_q == 8'h01);
	assign eng.msg_fault_cause = lvl[3];
	assign eng.overrun_cause = lvl[2];
	assign eng.tx_running = lvl[1];
	assign eng.ta_parity_err = lvl[0];
	assign eng.selftest_start = st_go;
endmodule

// ==== tb.sv ====
// Self-checking bench for the pointer and status register bank.
// Assumes reads answer one cycle later and the engine model drives the event port.
`timescale 1ns/1ps

module tb;
	import rtpsr_pkg::*;
	typedef struct packed {
		logic [15:0] mask;
		logic [15:0] val;
	} rtpsr_note_t;
	logic clk_sys, sys_rst, mem_halt, selftest_on_clr;
	rtpsr_bus_req_t bus_req;
	logic [15:0] rdata, word, rnd, d, w2;
	rtpsr_engine_t eng;
	rtpsr_cfg_t cfg;
	logic ill_pin, std_pin, bc_pin, par_on, a_on, b_on, go, on_a, ill, st_go, pend;
	logic [3:0] lvl;
	int mismatches, checks_done;
	rtpsr_note_t notes[$];
	rtpsr_note_t n;

	rtpsr_regs i_rtpsr_regs (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_req(bus_req), .rdata(rdata), .eng(eng),
		.illegal_cmd_pin(ill_pin), .std_variant_pin(std_pin), .broadcast_pin(bc_pin), .ta_parity_check_on(par_on),
		.bus_a_on(a_on), .bus_b_on(b_on), .cfg(cfg), .mem_halt(mem_halt), .selftest_on_clr(selftest_on_clr));
	rtpsr_eng_model i_rtpsr_eng_model (.clk_sys(clk_sys), .sys_rst(sys_rst), .go(go), .word(word), .on_a(on_a),
		.ill(ill), .lvl(lvl), .st_go(st_go), .eng(eng));

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	// Every bus task ends on a rising edge, so strobes never get two assignments in one step.
	task automatic op(input logic w, input logic r, input logic [1:0] a, input logic [15:0] dd);
		rnd = lfsr(rnd);
		bus_req <= '{addr: a, wdata: dd, wr: w, rd: r};
		@(posedge clk_sys);
	endtask
	task automatic idle(input int k);
		repeat (k) op(1'b0, 1'b0, rnd[1:0], rnd);
	endtask
	task automatic rd(input logic [1:0] a, input logic [15:0] m, input logic [15:0] v);
		notes.push_back('{m, v});
		op(1'b0, 1'b1, a, rnd);
	endtask
	task automatic msg(input logic [15:0] w, input logic a, input logic il);
		go <= 1'b1;
		word <= w;
		on_a <= a;
		ill <= il;
		idle(1);
		go <= 1'b0;
	endtask
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	always @(posedge clk_sys) pend <= bus_req.rd;
	always @(negedge clk_sys) begin
		if (pend === 1'b1) begin
			n = notes.pop_front();
			check(rdata & n.mask, n.val);
		end else if (!sys_rst && rdata !== 16'h0000) begin
			check(rdata, 16'h0000);
		end
	end

	initial begin
		repeat (3000) @(posedge clk_sys);
		mismatches++;
		$display("Error at %0t: run did not finish", $time);
		test_done();
	end

	initial begin
		sys_rst = 1'b1;
		bus_req = '0;
		{ill_pin, std_pin, bc_pin, par_on, b_on, go, on_a, ill, st_go} = 9'h000;
		a_on = 1'b1;
		lvl = 4'h0;
		word = 16'h0000;
		rnd = 16'h0058;
		mismatches = 0;
		checks_done = 0;
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		idle(6);
		op(1'b1, 1'b0, OFF_OP_STATE, 16'hFFFF);
		op(1'b1, 1'b0, OFF_LAST_CMD, 16'hFFFF);
		rd(OFF_BASE_CFG, 16'hFFFF, BASE_CFG_RST);
		rd(OFF_LAST_CMD, 16'hFFFF, LAST_CMD_RST);
		rd(OFF_OP_STATE, 16'hFFFF, 16'h1320);
		rd(OFF_ST_HALT, 16'hFFFF, DATA_ZERO);
		idle(1);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			d = rnd;
			d[3:0] = (i == 0) ? 4'h3 : (i == 1) ? 4'hF : 4'(3 + rnd[3:0] % 13);
			for (int j = 0; j < 2; j++) begin
				op(1'b1, 1'b0, OFF_BASE_CFG, d ^ 16'(j << 5));
				rd(OFF_BASE_CFG, 16'hFFFF, d ^ 16'(j << 5));
				idle(1);
				check({6'h00, cfg.ptr_block_base_hi}, {6'h00, d[15:6]});
				check({15'h0000, cfg.single_buf_sel}, {15'h0000, d[4]});
				check({12'h000, cfg.rx_buf_log2_size}, {12'h000, d[3:0]});
			end
		end
		$display("test config done");
		for (int i = 0; i < 2; i++) begin
			w2 = {rnd[15:10], 5'(1 + rnd[4:0] % 30), rnd[4:0]};
			msg(w2, i[0], 1'b0);
			idle(1);
			rd(OFF_OP_STATE, 16'h802E, 16'h8022 | 16'(i << 2));
			idle(8);
			rd(OFF_OP_STATE, 16'hC002, 16'h4000);
			idle(1);
			rd(OFF_OP_STATE, 16'h4000, DATA_ZERO);
			rd(OFF_LAST_CMD, 16'hFFFF, w2);
			idle(1);
			check({10'h000, cfg.ptr_block_low}, {10'h000, w2[10:5]});
		end
		$display("test message done");
		w2 = {rnd[15:11], 1'b1, SA_MODE_0, MC_INHIBIT_TFLAG};
		msg(w2, 1'b1, 1'b0);
		idle(8);
		rd(OFF_OP_STATE, 16'h0220, DATA_ZERO);
		d = {rnd[15:11], 1'b1, SA_MODE_1, MC_TX_LAST_CMD};
		msg(d, 1'b1, 1'b0);
		idle(8);
		rd(OFF_LAST_CMD, 16'hFFFF, w2);
		std_pin <= 1'b1;
		idle(6);
		msg(d, 1'b1, 1'b0);
		idle(8);
		rd(OFF_LAST_CMD, 16'hFFFF, d);
		rd(OFF_OP_STATE, 16'h0060, 16'h0040);
		$display("test mode done");
		d = {rnd[15:11], 1'b0, 5'h03, rnd[4:0]};
		msg(d, 1'b0, 1'b1);
		idle(3);
		rd(OFF_OP_STATE, 16'h0008, DATA_ZERO);
		ill_pin <= 1'b1;
		idle(6);
		msg(d, 1'b0, 1'b0);
		idle(3);
		rd(OFF_OP_STATE, 16'h0008, 16'h0008);
		idle(1);
		rd(OFF_OP_STATE, 16'h0008, DATA_ZERO);
		{std_pin, ill_pin} <= 2'b00;
		idle(6);
		msg(d, 1'b0, 1'b1);
		idle(3);
		rd(OFF_OP_STATE, 16'h0008, 16'h0008);
		$display("test illegal done");
		idle(7);
		rd(OFF_OP_STATE, 16'h0000, DATA_ZERO);
		msg(d, 1'b1, 1'b0);
		idle(4);
		// The valid message pulse lands in the very cycle in which this read clears the flags.
		rd(OFF_OP_STATE, 16'h4002, 16'h0002);
		idle(1);
		rd(OFF_OP_STATE, 16'h4000, 16'h4000);
		idle(7);
		lvl <= 4'hC;
		idle(3);
		for (int i = 0; i < 4; i++) begin
			if (i == 2) begin
				lvl <= 4'h0;
			end
			rd(OFF_OP_STATE, 16'h2001, (i < 3) ? 16'h2001 : DATA_ZERO);
			idle(2);
		end
		$display("test clear done");
		lvl <= 4'h3;
		{bc_pin, b_on, a_on} <= 3'b110;
		idle(6);
		rd(OFF_OP_STATE, 16'h1590, 16'h1490);
		par_on <= 1'b1;
		idle(2);
		rd(OFF_OP_STATE, 16'h1190, 16'h0090);
		{lvl, a_on} <= 5'h01;
		idle(2);
		rd(OFF_OP_STATE, 16'h1110, 16'h1100);
		$display("test live done");
		st_go <= 1'b1;
		idle(1);
		st_go <= 1'b0;
		idle(2);
		rd(OFF_OP_STATE, 16'h0800, 16'h0800);
		op(1'b1, 1'b0, OFF_ST_HALT, rnd);
		#1;
		check({14'h0000, mem_halt, selftest_on_clr}, 16'h0003);
		idle(1);
		#1;
		check({14'h0000, mem_halt, selftest_on_clr}, 16'h0000);
		idle(1);
		rd(OFF_OP_STATE, 16'h0800, DATA_ZERO);
		idle(2);
		$display("test halt done");
		test_done();
	end
endmodule
